// ### verilog/pan_ctrl.v
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "pan_map.vh"

module pan_ctrl #(
   parameter [32:0] SILENCE_CYC = `PAN_SILENCE_CYC
) (
   input  wire        clock,
   input  wire        srst,
   input  wire [3:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   input  wire        hs_done,
   input  wire [4:0]  rx_ds_wc_margin,
   input  wire [4:0]  rx_ds_cc_margin,
   input  wire [4:0]  rx_us_wc_margin,
   input  wire [4:0]  rx_us_cc_margin,
   input  wire [15:0] downstream_caps,
   input  wire        probe_done,
   output reg         hs_start_r,
   output reg  [1:0]  hs_txn_r,
   output reg         hs_half_duplex_r,
   output reg         hs_carrier_a4_r,
   output reg         tx_margin_octets_r,
   output reg  [4:0]  tx_us_wc_margin_r,
   output reg  [4:0]  tx_us_cc_margin_r,
   output reg  [4:0]  tx_ds_wc_margin_r,
   output reg  [4:0]  tx_ds_cc_margin_r,
   output reg  [15:0] adv_caps_r,
   output reg  [3:0]  tx_backoff_setting_r,
   output reg         probe_start_r,
   output reg  [2:0]  probe_scr_r,
   output reg  [5:0]  probe_dur_r,
   output reg  [4:0]  probe_wc_margin_r,
   output reg  [4:0]  probe_cc_margin_r,
   output reg         probe_act_mapper_r,
   output reg         probe_shared_shaper_r,
   output reg         regen_silence_request_r,
   output reg         act_start_r,
   output reg  [12:0] payload_rate_r,
   output reg  [3:0]  lead_time_r
);

   // fsm states
   localparam [3:0] ST_IDLE   = 4'h0;
   localparam [3:0] ST_SILENT = 4'h1;
   localparam [3:0] ST_CAPX   = 4'h2;
   localparam [3:0] ST_PROBEX = 4'h3;
   localparam [3:0] ST_PROBE  = 4'h4;
   localparam [3:0] ST_CAPX2  = 4'h5;
   localparam [3:0] ST_SELECT = 4'h6;
   localparam [3:0] ST_ACTIVE = 4'h7;

   // margin check: snr - req >= code - 10, kept unsigned
   function admit;
      input [7:0] snr;
      input [7:0] req;
      input [4:0] code;
      begin
         admit = ({2'b00, snr} + `PAN_MARGIN_OFS) >= ({2'b00, req} + {5'h00, code});
      end
   endfunction

   // register file and sequencer state
   reg  [8:0]  ctrl_r;
   reg  [16:0] probe_cfg_r;
   reg  [12:0] margin_r;
   reg  [10:0] rate_r;
   reg  [15:0] caps_r;
   reg  [23:0] snr_r;
   reg         caps_dirty_r;
   reg         err_param_r;
   reg  [3:0]  state_r;
   reg  [3:0]  state_nxt;
   reg  [32:0] sil_cnt_r;
   reg         go_r;

   // a write lands only on the accept cycle
   wire        acc_wr = avs_write & ~avs_waitrequest;
   wire        go_wr  = acc_wr & (avs_address == `PAN_REG_CTRL)
                        & avs_writedata[`PAN_CTRL_GO];

   // control bits
   wire        central  = ctrl_r[`PAN_CTRL_CENTRAL];
   wire        probe_en = ctrl_r[`PAN_CTRL_PROBE];
   wire        prior    = ctrl_r[`PAN_CTRL_PRIOR];
   wire        rsp      = ctrl_r[`PAN_CTRL_RSP];
   wire        use_rem  = ctrl_r[`PAN_CTRL_USEREM];
   wire        regen    = ctrl_r[`PAN_CTRL_REGEN];
   wire        wc_en    = ctrl_r[`PAN_CTRL_WC];
   wire        cc_en    = ctrl_r[`PAN_CTRL_CC];

   // probe and rate fields
   wire [2:0]  scr      = probe_cfg_r[2:0];
   wire [3:0]  tx_backoff_setting      = probe_cfg_r[6:3];
   wire [5:0]  dur      = probe_cfg_r[12:7];
   wire [3:0]  lead     = probe_cfg_r[16:13];
   wire [5:0]  base_n   = rate_r[5:0];
   wire [2:0]  sub_i    = rate_r[8:6];
   wire [1:0]  spec     = rate_r[10:9];

   // parameter sanity before a session may start
   wire scr_bad  = (scr == `PAN_SCR_RSVD) | (scr == `PAN_SCR_BAD);
   wire lead_bad = (lead < `PAN_LEAD_MIN) | (lead > `PAN_LEAD_MAX);
   wire sub_bad  = (spec == `PAN_SPEC_ASYM_A) & (sub_i > 3'h1);
   wire dur_bad  = (dur == 6'h00);
   wire cfg_bad  = scr_bad | lead_bad | sub_bad | dur_bad;

   // margins in force: central chooses, remote obeys the central's values
   wire [4:0] wc_eff = central ? (use_rem ? rx_us_wc_margin : margin_r[4:0])
                               : rx_ds_wc_margin;
   wire [4:0] cc_eff = central ? (use_rem ? rx_us_cc_margin : margin_r[12:8])
                               : rx_ds_cc_margin;

   // rate admission after probing, per noise condition
   wire ok_wc = admit(snr_r[7:0], snr_r[23:16], probe_wc_margin_r);
   wire ok_cc = admit(snr_r[15:8], snr_r[23:16], probe_cc_margin_r);
   wire rate_ok = (~wc_en | ok_wc) & (~cc_en | ok_cc);

   // capabilities to advertise; regenerator narrows by downstream view
   wire [15:0] own_caps = regen ? (caps_r & downstream_caps) : caps_r;

   // payload rate; sub-rate dropped on the wide asymmetric spectra
   wire [12:0] sub_eff = (spec == `PAN_SPEC_ASYM_B) ? 13'h0000 : {10'h000, sub_i};
   wire [12:0] rate_calc = (`PAN_RATE_BASE * {7'h00, base_n})
                         + (`PAN_RATE_SUB * sub_eff);

   // next state of the handshake sequencer
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (go_r & ~cfg_bad) begin
               if (rsp)
                  state_nxt = ST_SILENT;
               else if (caps_dirty_r | ~prior)
                  state_nxt = ST_CAPX;
               else
                  state_nxt = ST_SELECT;
            end
         end
         ST_SILENT: begin
            if (sil_cnt_r == 33'h000000000)
               state_nxt = ST_IDLE;
         end
         ST_CAPX: begin
            if (hs_done)
               state_nxt = (probe_en & ~prior) ? ST_PROBEX : ST_SELECT;
         end
         ST_PROBEX: begin
            if (hs_done)
               state_nxt = ST_PROBE;
         end
         ST_PROBE: begin
            if (probe_done)
               state_nxt = ST_CAPX2;
         end
         ST_CAPX2: begin
            if (hs_done)
               state_nxt = ST_SELECT;
         end
         ST_SELECT: begin
            if (hs_done)
               state_nxt = ST_ACTIVE;
         end
         ST_ACTIVE: begin
            // go only parks in idle; a second go starts
            if (go_r)
               state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // sequencer registers and link strobes
   always @(posedge clock) begin
      if (srst) begin
         state_r       <= ST_IDLE;
         hs_start_r    <= 1'b0;
         hs_txn_r      <= `PAN_TXN_CAP;
         probe_start_r <= 1'b0;
         act_start_r   <= 1'b0;
         sil_cnt_r     <= 33'h000000000;
         err_param_r   <= 1'b0;
         regen_silence_request_r <= 1'b0;
      end else begin
         // start strobes idle low, raised on entry only
         state_r       <= state_nxt;
         hs_start_r    <= 1'b0;
         probe_start_r <= 1'b0;
         act_start_r   <= 1'b0;
         // a refused go leaves its flag in status, and its cause unless duration is zero
         if (go_r & (state_r == ST_IDLE))
            err_param_r <= cfg_bad;
         if (state_nxt != state_r) begin
            case (state_nxt)
               ST_CAPX: begin
                  hs_start_r <= 1'b1;
                  hs_txn_r   <= `PAN_TXN_CAP;
               end
               ST_CAPX2: begin
                  hs_start_r <= 1'b1;
                  hs_txn_r   <= `PAN_TXN_CAP;
               end
               ST_SELECT: begin
                  hs_start_r <= (state_r == ST_IDLE);
                  hs_txn_r   <= `PAN_TXN_SELECT;
               end
               ST_PROBEX: begin
                  hs_txn_r <= `PAN_TXN_PROBE;
               end
               ST_PROBE: begin
                  probe_start_r <= 1'b1;
               end
               ST_ACTIVE: begin
                  act_start_r <= 1'b1;
               end
               default: begin
                  hs_txn_r <= hs_txn_r;
               end
            endcase
         end
         // silent interval counts down from the full minute
         if ((state_r == ST_IDLE) & (state_nxt == ST_SILENT))
            sil_cnt_r <= SILENCE_CYC - 33'h000000001;
         else if (sil_cnt_r != 33'h000000000)
            sil_cnt_r <= sil_cnt_r - 33'h000000001;
         // level tracks next state, so it drops with the count
         regen_silence_request_r <= (state_nxt == ST_SILENT);
      end
   end

   // latch negotiated probe set at probe entry, hold until the next probe exchange ends
   always @(posedge clock) begin
      if (srst) begin
         probe_scr_r          <= 3'h0;
         probe_dur_r          <= 6'h01;
         tx_backoff_setting_r <= 4'h0;
         probe_wc_margin_r    <= 5'h0f;
         probe_cc_margin_r    <= 5'h0f;
         lead_time_r          <= 4'h1;
         payload_rate_r       <= 13'h0000;
      end else if ((state_r == ST_PROBEX) & hs_done) begin
         // taken once, held through probe and activation
         probe_scr_r          <= scr;
         probe_dur_r          <= dur;
         tx_backoff_setting_r <= tx_backoff_setting;
         probe_wc_margin_r    <= wc_eff;
         probe_cc_margin_r    <= cc_eff;
      end else if ((state_r == ST_SELECT) & hs_done) begin
         payload_rate_r <= rate_calc;
         lead_time_r    <= lead;
      end
   end

   // handshake field drive; central side margins go out as equal up/down pairs
   always @(posedge clock) begin
      if (srst) begin
         tx_us_wc_margin_r  <= 5'h0f;
         tx_us_cc_margin_r  <= 5'h0f;
         tx_ds_wc_margin_r  <= 5'h0f;
         tx_ds_cc_margin_r  <= 5'h0f;
         tx_margin_octets_r <= 1'b0;
         adv_caps_r         <= 16'h0000;
         hs_half_duplex_r   <= 1'b1;
         hs_carrier_a4_r    <= `PAN_CARRIER_A4;
         probe_act_mapper_r    <= 1'b1;
         probe_shared_shaper_r <= 1'b1;
      end else begin
         // only the mandatory tone set is offered
         hs_half_duplex_r      <= 1'b1;
         hs_carrier_a4_r       <= `PAN_CARRIER_A4;
         probe_act_mapper_r    <= 1'b1;
         probe_shared_shaper_r <= 1'b1;
         // remote side echoes the central's downstream codes
         tx_ds_wc_margin_r <= wc_eff;
         tx_ds_cc_margin_r <= cc_eff;
         tx_us_wc_margin_r <= central ? wc_eff : margin_r[4:0];
         tx_us_cc_margin_r <= central ? cc_eff : margin_r[12:8];
         // octets go out whenever probing is offered
         tx_margin_octets_r <= probe_en;
         // second exchange limited by probe outcome
         if (state_r == ST_CAPX2)
            adv_caps_r <= rate_ok ? own_caps : 16'h0000;
         else
            adv_caps_r <= own_caps;
      end
   end

   // go pulse from bus write
   always @(posedge clock) begin
      if (srst)
         go_r <= 1'b0;
      else
         go_r <= go_wr;
   end

   // software registers; caps write marks them dirty, set beats clear
   always @(posedge clock) begin
      if (srst) begin
         ctrl_r       <= `PAN_CTRL_RST;
         probe_cfg_r  <= `PAN_PROBE_RST;
         margin_r     <= `PAN_MARGIN_RST;
         rate_r       <= `PAN_RATE_RST;
         caps_r       <= 16'h0000;
         snr_r        <= 24'h000000;
         caps_dirty_r <= 1'b0;
      end else begin
         // clear before the write, so a caps write wins
         if ((state_r == ST_CAPX) & hs_done)
            caps_dirty_r <= 1'b0;
         // unmapped and read-only words hit the default
         if (acc_wr) begin
            case (avs_address)
               `PAN_REG_CTRL: begin
                  ctrl_r <= {avs_writedata[8:1], 1'b0};
               end
               `PAN_REG_PROBE: begin
                  probe_cfg_r <= avs_writedata[16:0];
               end
               `PAN_REG_MARGIN: begin
                  margin_r <= avs_writedata[12:0];
               end
               `PAN_REG_RATE: begin
                  rate_r <= avs_writedata[10:0];
               end
               `PAN_REG_CAPS: begin
                  caps_r       <= avs_writedata[15:0];
                  caps_dirty_r <= 1'b1;
               end
               `PAN_REG_SNR: begin
                  snr_r <= avs_writedata[23:0];
               end
               default: begin
                  snr_r <= snr_r;
               end
            endcase
         end
      end
   end

   // avalon handshake: one wait cycle, then a single-cycle accept
   always @(posedge clock) begin
      if (srst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
      end else begin
         // low one cycle; master must hold until then
         avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
         // data taken on the take edge, stands at accept
         if (avs_read & avs_waitrequest) begin
            case (avs_address)
               `PAN_REG_CTRL:   avs_readdata <= {23'h000000, ctrl_r};
               `PAN_REG_PROBE:  avs_readdata <= {15'h0000, probe_cfg_r};
               `PAN_REG_MARGIN: avs_readdata <= {19'h00000, margin_r};
               `PAN_REG_RATE:   avs_readdata <= {21'h000000, rate_r};
               `PAN_REG_CAPS:   avs_readdata <= {16'h0000, caps_r};
               `PAN_REG_SNR:    avs_readdata <= {8'h00, snr_r};
               // status: state, dirty, error, its scrambler, lead and sub-rate causes
               `PAN_REG_STATUS: avs_readdata <= {20'h00000, rate_ok, sub_bad,
                                                 lead_bad, scr_bad, err_param_r,
                                                 caps_dirty_r, 2'b00, state_r};
               `PAN_REG_RESULT: avs_readdata <= {adv_caps_r, 3'h0, payload_rate_r};
               default:         avs_readdata <= 32'h00000000;
            endcase
         end
      end
   end

endmodule // pan_ctrl

// ### verilog/pan_map.vh
// Summary of operation
// - probe scrambler index is three bits; 110 reserved, 111 never selected.
// - probe transmit reuses the activation mapper and the common spectral shaper.
// - rate admitted only when estimated SNR minus required SNR reaches target margin.
// - with both margin types enabled, admitted rates are the intersection of both checks.
// - central side sends identical up and down margins, remote's or its own.
// - remote side judges rates with the downstream margins sent by the central side.
// - probing is optional; known loop and peer go straight to mode select.
// - rate repartition lead time counts frames; only 1 to 15 allowed.
// - backoff field is a count of 1 dB steps.
// - probe duration field counts 50 ms units per probe segment.
// - margin is 5-bit code times 1 dB minus 10 dB, two separate octets.
// - both margin octets sent with probe capability; their values ignored then.
// - regenerator silence request forces a one minute silent interval.
// - symmetric payload rate is base times 64 kbit/s plus sub-rate times 8.
// - asymmetric 768/1536 allow sub-rate 0 or 8 only; 2048/2304 ignore sub-rate.
// - handshake runs half duplex on the A4 carrier set of the 4 kHz family.
// - advertise only enabled functions; changed capabilities force a capabilities exchange.
// - without prior knowledge open with capabilities exchange, else go to mode select.
// - probe entry is probe request, probe answer with echo, acknowledge, then probing.
// - after probing a new session exchanges capabilities limited by the probed loop.
// - once parameters are selected the handshake ends and activation starts.
// - remote-side regenerator advertises own caps AND downstream caps; backoff stays local.
`ifndef PAN_MAP_VH
`define PAN_MAP_VH
// register word offsets
`define PAN_REG_CTRL    4'h0
`define PAN_REG_PROBE   4'h1
`define PAN_REG_MARGIN  4'h2
`define PAN_REG_RATE    4'h3
`define PAN_REG_CAPS    4'h4
`define PAN_REG_SNR     4'h5
`define PAN_REG_STATUS  4'h6
`define PAN_REG_RESULT  4'h7
// control bits
`define PAN_CTRL_GO     0
`define PAN_CTRL_CENTRAL 1
`define PAN_CTRL_PROBE  2
`define PAN_CTRL_PRIOR  3
`define PAN_CTRL_RSP    4
`define PAN_CTRL_USEREM 5
`define PAN_CTRL_REGEN  6
`define PAN_CTRL_WC     7
`define PAN_CTRL_CC     8
// reset values
`define PAN_CTRL_RST    9'h184
`define PAN_PROBE_RST   17'h02114
`define PAN_MARGIN_RST  13'h0f0f
`define PAN_RATE_RST    11'h003
// scrambler codes
`define PAN_SCR_RSVD    3'h6
`define PAN_SCR_BAD     3'h7
// lead time limits in frames
`define PAN_LEAD_MIN    4'h1
`define PAN_LEAD_MAX    4'hf
// margin offset in dB, rate steps in kbit/s
`define PAN_MARGIN_OFS  10'h00a
`define PAN_RATE_BASE   13'h0040
`define PAN_RATE_SUB    13'h0008
// spectrum kinds
`define PAN_SPEC_SYM    2'h0
`define PAN_SPEC_ASYM_A 2'h1
`define PAN_SPEC_ASYM_B 2'h2
// handshake transactions and carrier
`define PAN_TXN_CAP     2'h0
`define PAN_TXN_PROBE   2'h1
`define PAN_TXN_SELECT  2'h2
`define PAN_CARRIER_A4  1'b1
// timing
`define PAN_CLK_KHZ     100000
`define PAN_SILENCE_MS  60000
`define PAN_SILENCE_CYC 33'h165a0bc00
`endif

// ### testbench/pan_ctrl_chk.sv
`timescale 1ns/1ps
`include "pan_map.vh"
module pan_ctrl_chk #(
   parameter [32:0] SILENCE_CYC = 33'h64
) (
   input wire        clock,
   input wire        srst,
   input wire        avs_read,
   input wire        avs_write,
   input wire        avs_waitrequest,
   input wire        hs_done,
   input wire        probe_done,
   input wire        hs_start_r,
   input wire [1:0]  hs_txn_r,
   input wire        hs_half_duplex_r,
   input wire        hs_carrier_a4_r,
   input wire [3:0]  tx_backoff_setting_r,
   input wire        probe_start_r,
   input wire [2:0]  probe_scr_r,
   input wire [5:0]  probe_dur_r,
   input wire        probe_act_mapper_r,
   input wire        probe_shared_shaper_r,
   input wire        regen_silence_request_r,
   input wire        act_start_r,
   input wire [3:0]  lead_time_r
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   // silent cycles so far, too long for a repetition
   reg [32:0] sil_r;
   always @(posedge clock) begin
      sil_r <= (srst || !regen_silence_request_r) ? 33'h0 : sil_r + 33'h1;
   end
   // steps of one bus access and of a held probe setup
   sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
   sequence s_ack; !avs_waitrequest ##1 avs_waitrequest; endsequence
   sequence s_hold;
      ($stable(probe_scr_r) && $stable(probe_dur_r) && $stable(tx_backoff_setting_r)) [*8];
   endsequence
   AST_BUS_ACK: assert property (s_req |=> s_ack)
      else $error("bus answer late");
   AST_SCR_OK: assert property (probe_start_r |-> probe_scr_r < `PAN_SCR_RSVD)
      else $error("bad scrambler index");
   AST_SHAPER: assert property (
      probe_start_r |-> probe_act_mapper_r && probe_shared_shaper_r)
      else $error("probe mapper or shaper off");
   AST_TONE: assert property (hs_start_r |-> hs_half_duplex_r && hs_carrier_a4_r)
      else $error("handshake tone mode wrong");
   AST_PROBE_HOLD: assert property (probe_start_r |=> s_hold)
      else $error("probe setup moved");
   AST_PROBE_GO: assert property (
      hs_done && hs_txn_r == `PAN_TXN_PROBE |-> ##[1:2] probe_start_r)
      else $error("probe did not follow exchange");
   AST_SESSION2: assert property (
      probe_done |-> ##[1:2] hs_start_r && hs_txn_r == `PAN_TXN_CAP)
      else $error("no caps session after probe");
   AST_ACT_GO: assert property (
      hs_done && hs_txn_r == `PAN_TXN_SELECT |-> ##[1:2] act_start_r)
      else $error("activation did not follow select");
   AST_ACT_PULSE: assert property (
      act_start_r |-> hs_txn_r == `PAN_TXN_SELECT ##1 !act_start_r)
      else $error("activation pulse wrong");
   AST_LEAD: assert property (act_start_r |-> lead_time_r >= `PAN_LEAD_MIN)
      else $error("lead time zero");
   AST_SILENCE: assert property (
      $fell(regen_silence_request_r) |-> sil_r + 33'h1 >= SILENCE_CYC
      && sil_r <= SILENCE_CYC + 33'h1)
      else $error("silent interval length wrong");
endmodule // pan_ctrl_chk
bind pan_ctrl pan_ctrl_chk #(.SILENCE_CYC(SILENCE_CYC)) u_chk (.*);

// ### testbench/pan_peer_model.sv
`timescale 1ns/1ps
module pan_peer_model (
   input wire       clock,
   input wire       srst,
   input wire       slow,
   input wire       hs_start_r,
   input wire [1:0] hs_txn_r,
   input wire       probe_start_r,
   output reg       hs_done,
   output reg       probe_done
);
   reg  [1:0] txn_q_r;
   reg  [4:0] hs_cnt_r;
   reg  [4:0] pr_cnt_r;
   wire [4:0] dly = slow ? 5'h14 : 5'h02;
   // one done pulse per transaction and per probe run; slow peer stretches each
   always @(posedge clock) begin
      txn_q_r <= hs_txn_r;
      hs_done <= 1'h0;
      probe_done <= 1'h0;
      if (srst) begin
         hs_cnt_r <= 5'h0;
         pr_cnt_r <= 5'h0;
      end else begin
         if (hs_start_r || txn_q_r != hs_txn_r) begin
            hs_cnt_r <= dly;
         end else if (hs_cnt_r != 5'h0) begin
            hs_cnt_r <= hs_cnt_r - 5'h1;
            hs_done <= hs_cnt_r == 5'h1;
         end
         if (probe_start_r) begin
            pr_cnt_r <= dly;
         end else if (pr_cnt_r != 5'h0) begin
            pr_cnt_r <= pr_cnt_r - 5'h1;
            probe_done <= pr_cnt_r == 5'h1;
         end
      end
   end
endmodule // pan_peer_model

// ### testbench/pan_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "pan_map.vh"
module pan_ctrl_tb_top;
   reg         clock, srst, avs_read, avs_write, slow;
   reg  [3:0]  avs_address, tx_backoff_setting, lead;
   reg  [31:0] avs_writedata, rdat, x, r, s;
   reg  [4:0]  rx_ds_wc_margin, rx_ds_cc_margin, rx_us_wc_margin, rx_us_cc_margin, cw, cc;
   reg  [15:0] downstream_caps, caps, ecaps;
   reg  [7:0]  ew, ec, rq;
   reg  [2:0]  scr, ri;
   reg  [5:0]  dur, n;
   reg  [1:0]  sp, txn_at;
   wire [31:0] avs_readdata;
   wire        avs_waitrequest, hs_done, probe_done, hs_start_r, probe_start_r, act_start_r;
   wire        regen_silence_request_r, tx_margin_octets_r;
   wire [1:0]  hs_txn_r;
   wire [4:0]  tx_us_wc_margin_r, tx_us_cc_margin_r, tx_ds_wc_margin_r, tx_ds_cc_margin_r;
   wire [3:0]  tx_backoff_setting_r, lead_time_r;
   wire [2:0]  probe_scr_r;
   wire [5:0]  probe_dur_r;
   wire [12:0] payload_rate_r;
   wire [15:0] adv_caps_r;
   wire [4:0]  probe_wc_margin_r, probe_cc_margin_r;
   integer     mismatches, check_count, cyc, n_hs, n_pr, k, it;

   pan_ctrl #(.SILENCE_CYC(33'h64)) u_dut (.*, .hs_half_duplex_r(), .hs_carrier_a4_r(),
      .probe_act_mapper_r(), .probe_shared_shaper_r());
   pan_peer_model u_peer (.*);

   // 100 MHz clock
   initial begin
      clock = 1'h0;
      forever #5 clock = ~clock;
   end
   // count session and probe starts; hang guard
   always @(posedge clock) begin
      cyc = cyc + 1;
      if (hs_start_r === 1'h1) begin
         n_hs = n_hs + 1;
         txn_at = hs_txn_r;
      end
      if (probe_start_r === 1'h1) n_pr = n_pr + 1;
      if (cyc == 20000) begin
         mismatches = mismatches + 1;
         summarize;
      end
   end

   function [31:0] rnd(input [31:0] v);
      reg [31:0] t;
      begin
         t = v ^ (v << 13);
         t = t ^ (t >> 17);
         rnd = t ^ (t << 5);
      end
   endfunction
   function ok_f(input [7:0] e, input [7:0] q, input [4:0] c);
      ok_f = ({1'h0, e} + 9'h00a) >= ({1'h0, q} + {4'h0, c});
   endfunction
   function [12:0] exp_rate(input [5:0] nb, input [2:0] ib, input [1:0] sb);
      exp_rate = nb * `PAN_RATE_BASE + (sb == `PAN_SPEC_ASYM_B ? 13'h0 : ib * `PAN_RATE_SUB);
   endfunction
   // one access, held until waitrequest drops; an idle edge keeps drives apart
   task bus(input [3:0] a, input [31:0] d, input rd);
      begin
         avs_address <= a;
         avs_writedata <= d;
         avs_read <= rd;
         avs_write <= !rd;
         @(posedge clock);
         while (avs_waitrequest !== 1'h0) @(posedge clock);
         rdat = avs_readdata;
         avs_read <= 1'h0;
         avs_write <= 1'h0;
         @(posedge clock);
      end
   endtask
   task ck(input [31:0] g, input [31:0] e);
      begin
         check_count = check_count + 1;
         if (g !== e) begin
            mismatches = mismatches + 1;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   task summarize;
      begin
         $display("checks %0d mismatches %0d", check_count, mismatches);
         if (mismatches == 0 && check_count > 0) $display("STATUS OK");
         else $display("STATUS NOT OK");
         $finish;
      end
   endtask

   initial begin
      srst = 1'h1;
      {avs_read, avs_write, slow, avs_address, avs_writedata} = 39'h0;
      {rx_ds_wc_margin, rx_ds_cc_margin, rx_us_wc_margin, rx_us_cc_margin} = 20'h0;
      downstream_caps = 16'h0;
      {mismatches, check_count, cyc, n_hs, n_pr} = 0;
      x = 32'h22;
      repeat (20) @(posedge clock);
      srst <= 1'h0;
      // reset values, then a read-only and an unmapped word
      bus(4'h7, 32'hffffffff, 1'h0);
      bus(4'h9, 32'hffffffff, 1'h0);
      for (k = 0; k < 7; k = k + 1) begin
         s = k < 5 ? k : k * 2 - 3;
         bus(s[3:0], 32'h0, 1'h1);
         ck(rdat, k == 0 ? 32'h184 : k == 1 ? 32'h2114 : k == 2 ? 32'hf0f : k == 3 ? 32'h3 : 0);
      end
      // refused setups: no session may start
      for (k = 0; k < 5; k = k + 1) begin
         s = k == 0 ? 32'h2086 : k == 1 ? 32'h2087 : k == 2 ? 32'h80 : k == 3 ? 32'h2000 : 32'h2080;
         bus(`PAN_REG_PROBE, s, 1'h0);
         bus(`PAN_REG_RATE, k == 4 ? 32'h283 : 32'h3, 1'h0);
         it = n_hs;
         bus(`PAN_REG_CTRL, 32'h1, 1'h0);
         bus(`PAN_REG_STATUS, 32'h0, 1'h1);
         ck(rdat & 32'h780, k < 2 ? 32'h180 : k == 2 ? 32'h280 : k == 3 ? 32'h80 : 32'h480);
         ck(n_hs - it, 0);
      end
      // random probed sessions, slow and prompt peer
      for (it = 0; it < 8; it = it + 1) begin
         x = rnd(x);
         r = x;
         scr = it == 0 ? 3'h5 : r[2:0] % 3'h6;
         tx_backoff_setting = r[6:3];
         dur = r[12:7] | 6'h01;
         lead = (r[16:13] == 4'h0 || it == 1) ? 4'hf : r[16:13];
         sp = r[18:17] % 2'h3;
         n = r[24:19] % 6'h22 + 6'h03;
         ri = sp == `PAN_SPEC_ASYM_A ? {2'h0, r[25]} : r[27:25];
         x = rnd(x);
         {rq, ec, ew} = {3'h0, x[14:10], 3'h0, x[9:5], 3'h0, x[4:0]};
         cw = x[19:15];
         cc = x[24:20];
         slow <= x[25];
         x = rnd(x);
         s = x;
         rx_ds_wc_margin <= s[4:0];
         rx_ds_cc_margin <= s[9:5];
         rx_us_wc_margin <= s[14:10];
         rx_us_cc_margin <= s[19:15];
         x = rnd(x);
         caps = x[31:16];
         downstream_caps <= x[15:0];
         bus(`PAN_REG_PROBE, {15'h0, lead, dur, tx_backoff_setting, scr}, 1'h0);
         bus(`PAN_REG_MARGIN, {19'h0, cc, 3'h0, cw}, 1'h0);
         bus(`PAN_REG_RATE, {21'h0, sp, ri, n}, 1'h0);
         bus(`PAN_REG_SNR, {8'h0, rq, ec, ew}, 1'h0);
         bus(`PAN_REG_CAPS, {16'h0, caps}, 1'h0);
         bus(`PAN_REG_CTRL, {23'h0, s[20], r[31:29], 3'h1, r[28], 1'h1}, 1'h0);
         // central own or remote codes; remote takes downstream codes
         if (!r[28]) {cc, cw} = s[9:0];
         else if (r[29]) {cw, cc} = {s[14:10], s[19:15]};
         ecaps = r[30] ? caps & downstream_caps : caps;
         if ((r[31] && !ok_f(ew, rq, cw)) || (s[20] && !ok_f(ec, rq, cc))) ecaps = 16'h0;
         while (probe_start_r !== 1'h1) @(negedge clock);
         ck(probe_scr_r, scr);
         ck(tx_backoff_setting_r, tx_backoff_setting);
         ck(probe_dur_r, dur);
         ck(tx_margin_octets_r, 1'h1);
         ck({tx_ds_wc_margin_r, tx_ds_cc_margin_r}, {cw, cc});
         ck({probe_wc_margin_r, probe_cc_margin_r}, {cw, cc});
         if (r[28]) ck({tx_us_wc_margin_r, tx_us_cc_margin_r}, {cw, cc});
         // second caps exchange: admission gates the advertised set
         while (hs_start_r !== 1'h1) @(negedge clock);
         @(negedge clock);
         ck(adv_caps_r, ecaps);
         while (act_start_r !== 1'h1) @(negedge clock);
         ck(lead_time_r, lead);
         ck(payload_rate_r, exp_rate(n, ri, sp));
         @(posedge clock);
         bus(`PAN_REG_RESULT, 32'h0, 1'h1);
         ck(rdat, {(r[30] ? caps & downstream_caps : caps), 3'h0, exp_rate(n, ri, sp)});
         bus(`PAN_REG_CTRL, 32'h1, 1'h0);
      end
      // known loop and peer go straight to select, unless caps changed
      for (k = 0; k < 2; k = k + 1) begin
         if (k == 1) bus(`PAN_REG_CAPS, 32'h5a5a, 1'h0);
         it = n_hs;
         s = n_pr;
         bus(`PAN_REG_CTRL, 32'h9, 1'h0);
         while (n_hs == it) @(negedge clock);
         ck(txn_at, k ? `PAN_TXN_CAP : `PAN_TXN_SELECT);
         while (act_start_r !== 1'h1) @(negedge clock);
         ck(n_pr - s, 0);
         @(posedge clock);
         bus(`PAN_REG_CTRL, 32'h1, 1'h0);
      end
      // regenerator silence request
      bus(`PAN_REG_CTRL, 32'h11, 1'h0);
      while (regen_silence_request_r !== 1'h1) @(negedge clock);
      k = 0;
      while (regen_silence_request_r === 1'h1) begin
         k = k + 1;
         @(negedge clock);
      end
      ck(k, 32'h64);
      summarize;
   end
endmodule // pan_ctrl_tb_top
